// [rtl/deglitch_timer.sv]
// Deglitch timer: counts while a condition holds, restarts when it drops
`timescale 1ns/100ps
module deglitch_timer #(
   parameter int CW = 24
) (
   // Clock and reset
   input  wire logic          clk_in,
   input  wire logic          reset_n_in,
   // Condition and limit
   input  wire logic          cond_in,
   input  wire logic [CW-1:0] limit_in,
   // Expired level
   output logic               done_out
);
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          done;
   } timer_state_type;

   timer_state_type s_q, s_d;

   always_comb begin
      s_d = s_q;
      if (!cond_in) begin
         s_d.cnt  = '0;   // see [RQ13]
         s_d.done = 1'b0;
      end else if (s_q.cnt + CW'(1) >= limit_in) begin
         s_d.done = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + CW'(1);
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign done_out = s_q.done;
endmodule : deglitch_timer

// [rtl/phase_cfg_pkg.sv]
// Package: register map, field layout, reset values and deglitch timing constants
package phase_cfg_pkg;

   // ==========================================================
   // Register map
   localparam logic [7:0] GATE_DRIVE_ADDR  = 8'h13;
   localparam logic [7:0] PHASE_CFG_ADDR   = 8'h14;
   localparam logic [7:0] GATE_DRIVE_RESET = 8'h6c;
   localparam logic [7:0] PHASE_CFG_RESET  = 8'h85;
   // Gate drive register bit 1 is reserved and reads zero
   localparam logic [7:0] GATE_DRIVE_WMASK = 8'hfd;

   // ==========================================================
   // Field positions
   localparam int HS_LSB   = 5;
   localparam int LS_LSB   = 2;
   localparam int OVX_BIT  = 0;
   localparam int TH_LSB   = 5;
   localparam int FS_BIT   = 4;
   localparam int ADD_LSB  = 2;
   localparam int DROP_LSB = 0;

   // ==========================================================
   // Threshold: code n means (n+2) A; hysteresis one amp
   localparam logic [2:0] TH_FORCE_DUAL = 3'h0;
   localparam logic [3:0] TH_OFFSET_A   = 4'h2;
   localparam logic [3:0] HYST_A        = 4'h1;

   // ==========================================================
   // Deglitch times (typical), in ns, and clock period
   localparam int  CLK_PERIOD_NS = 10;
   localparam real ADD_T0_NS  = 1700.0;
   localparam real ADD_T1_NS  = 5500.0;
   localparam real ADD_T2_NS  = 20000.0;
   localparam real ADD_T3_NS  = 86000.0;
   localparam real DROP_T0_NS = 93000.0;
   localparam real DROP_T1_NS = 1500000.0;
   localparam real DROP_T2_NS = 11000000.0;
   localparam real DROP_T3_NS = 94000000.0;
   localparam int  CNT_W      = 24;

   typedef enum logic {SINGLE_PHASE, DUAL_PHASE} phase_state_type;

endpackage : phase_cfg_pkg

// [rtl/phase_gate_config.sv]
// Top: gate drive and phase transition configuration registers and phase controller
// ==========================================================
// How it works
// [RQ1] High-side drive strength bits 7-5, reset 3, drive both first-phase high switches
// [RQ2] Low-side drive strength bits 4-2, reset 3, drive both first-phase low switches
// [RQ3] Extend clear: overvoltage guard needs enable, charging and battery switch on
// [RQ4] Extend set: overvoltage guard acts whenever its enable is set
// [RQ5] Gate drive register at 13h, reset 6Ch, bit 1 reads zero
// [RQ6] Phase register at 14h, reset 85h, restored by register reset command
// [RQ7] Threshold bits 7-5, reset 4; zero forces dual, else 3A to 9A
// [RQ8] Drop back to single phase at one amp below add threshold
// [RQ9] Threshold and force-single apply only in quasi dual-phase mode
// [RQ10] Force-single bit 4 holds single phase; otherwise automatic transitions
// [RQ11] Add deglitch bits 3-2, reset 1: 1.7, 5.5, 20, 86 us
// [RQ12] Drop deglitch bits 1-0, reset 1: 93us, 1.5ms, 11ms, 94ms
// [RQ13] Deglitch timers restart when the condition lapses early
// [RQ14] One fixed set of typical timer limits from the internal clock
`timescale 1ns/100ps
module phase_gate_config
   import phase_cfg_pkg::*;
#(
   parameter int DROP_T1_CYC = int'(DROP_T1_NS) / CLK_PERIOD_NS,
   parameter int DROP_T2_CYC = int'(DROP_T2_NS) / CLK_PERIOD_NS,
   parameter int DROP_T3_CYC = int'(DROP_T3_NS) / CLK_PERIOD_NS
) (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       reset_n_in,
   // Register port from the serial interface
   input  wire logic       reg_wr_in,
   input  wire logic [7:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   output logic      [7:0] reg_rdata_out,
   input  wire logic       reg_reset_in,
   // Converter status
   input  wire logic       quasi_dual_mode_in,
   input  wire logic       buck_mode_in,
   input  wire logic [3:0] load_current_a_in,
   // Overvoltage guard inputs
   input  wire logic       overvoltage_guard_enable_in,
   input  wire logic       charge_enable_in,
   input  wire logic       battery_switch_in,
   // Outputs to analog drivers
   output logic      [2:0] high_side_drive_strength_out,
   output logic      [2:0] low_side_drive_strength_out,
   output logic            battery_overvoltage_guard_out,
   output logic            dual_phase_out
);
   import phase_cfg_pkg::*;

   localparam int CW = CNT_W;

   // ==========================================================
   // Pin synchronisers
   typedef struct packed {
      logic [6:0] s1;
      logic [6:0] s2;
   } sync_state_type;
   sync_state_type y_q, y_d;

   always_comb begin
      y_d.s1 = {quasi_dual_mode_in, buck_mode_in, load_current_a_in, 1'b0};
      y_d.s2 = y_q.s1;
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         y_q <= '0;
      end else begin
         y_q <= y_d;
      end
   end

   logic       quasi_s;
   logic       buck_s;
   logic [3:0] load_s;
   assign quasi_s = y_q.s2[6];
   assign buck_s  = y_q.s2[5];
   assign load_s  = y_q.s2[4:1];

   // ==========================================================
   // Registers
   reg_access_if regs_if ();

   typedef struct packed {
      logic [7:0]      gate_drive;
      logic [7:0]      phase_cfg;
      phase_state_type phase;
      logic [7:0]      rdata;
      logic            guard;
   } top_state_type;
   top_state_type t_q, t_d;

   function automatic logic [7:0] read_reg(input logic [7:0] addr,
                                           input logic [7:0] gd,
                                           input logic [7:0] pc);
      logic [7:0] r;
      r = 8'h00;
      if (addr == GATE_DRIVE_ADDR) begin
         r = gd & GATE_DRIVE_WMASK;   // see [RQ5]
      end else if (addr == PHASE_CFG_ADDR) begin
         r = pc;
      end
      return r;
   endfunction : read_reg

   // ==========================================================
   // Deglitch limits
   function automatic logic [CW-1:0] cyc(input real ns);
      int c;
      c = int'(ns) / CLK_PERIOD_NS;
      if (c < 1) begin
         c = 1;
      end
      return CW'(c);
   endfunction : cyc

   logic [CW-1:0] add_limit;
   logic [CW-1:0] drop_limit;
   logic [1:0]    add_sel;
   logic [1:0]    drop_sel;
   assign add_sel  = regs_if.phase_cfg[ADD_LSB +: 2];
   assign drop_sel = regs_if.phase_cfg[DROP_LSB +: 2];

   // Typical values only; the min/max spread is not modelled
   always_comb begin
      unique case (add_sel)   // see [RQ11] see [RQ14]
         2'h0: begin
            add_limit = cyc(ADD_T0_NS);
         end
         2'h1: begin
            add_limit = cyc(ADD_T1_NS);
         end
         2'h2: begin
            add_limit = cyc(ADD_T2_NS);
         end
         2'h3: begin
            add_limit = cyc(ADD_T3_NS);
         end
      endcase
   end

   // Long drop times are parameters so a bench can shorten them
   always_comb begin
      unique case (drop_sel)  // see [RQ12] see [RQ14]
         2'h0: begin
            drop_limit = cyc(DROP_T0_NS);
         end
         2'h1: begin
            drop_limit = CW'(DROP_T1_CYC);
         end
         2'h2: begin
            drop_limit = CW'(DROP_T2_CYC);
         end
         2'h3: begin
            drop_limit = CW'(DROP_T3_CYC);
         end
      endcase
   end

   // ==========================================================
   // Phase conditions
   logic [2:0] th_code;
   logic [3:0] add_a;
   logic       add_cond;
   logic       drop_cond;
   logic       add_done;
   logic       drop_done;
   assign th_code   = regs_if.phase_cfg[TH_LSB +: 3];
   assign add_a     = {1'b0, th_code} + TH_OFFSET_A;              // see [RQ7]
   assign add_cond  = (t_q.phase == SINGLE_PHASE) && (load_s > add_a);
   assign drop_cond = (t_q.phase == DUAL_PHASE) && (load_s <= add_a - HYST_A); // see [RQ8]

   deglitch_timer #(.CW(CW)) add_timer (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .cond_in    (add_cond),
      .limit_in   (add_limit),
      .done_out   (add_done)
   );

   deglitch_timer #(.CW(CW)) drop_timer (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .cond_in    (drop_cond),
      .limit_in   (drop_limit),
      .done_out   (drop_done)
   );

   // ==========================================================
   // Next state
   always_comb begin
      t_d = t_q;
      if (reg_reset_in) begin
         t_d.gate_drive = GATE_DRIVE_RESET;
         t_d.phase_cfg  = PHASE_CFG_RESET;                        // see [RQ6]
      end else if (reg_wr_in && reg_addr_in == GATE_DRIVE_ADDR) begin
         t_d.gate_drive = reg_wdata_in & GATE_DRIVE_WMASK;        // see [RQ1] see [RQ2]
      end else if (reg_wr_in && reg_addr_in == PHASE_CFG_ADDR) begin
         t_d.phase_cfg = reg_wdata_in;
      end
      t_d.rdata = read_reg(reg_addr_in, t_q.gate_drive, t_q.phase_cfg);

      // Outside buck or quasi mode the second phase is not used
      if (!quasi_s || !buck_s) begin
         t_d.phase = SINGLE_PHASE;                                // see [RQ9]
      end else if (t_q.phase_cfg[FS_BIT]) begin
         t_d.phase = SINGLE_PHASE;                                // see [RQ10]
      end else if (th_code == TH_FORCE_DUAL) begin
         t_d.phase = DUAL_PHASE;                                  // see [RQ7]
      end else if (add_done) begin
         t_d.phase = DUAL_PHASE;                                  // see [RQ11]
      end else if (drop_done) begin
         t_d.phase = SINGLE_PHASE;                                // see [RQ12]
      end

      if (t_q.gate_drive[OVX_BIT]) begin
         t_d.guard = overvoltage_guard_enable_in;                 // see [RQ4]
      end else begin
         t_d.guard = overvoltage_guard_enable_in && charge_enable_in
                     && battery_switch_in;                        // see [RQ3]
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         t_q.gate_drive <= GATE_DRIVE_RESET;
         t_q.phase_cfg  <= PHASE_CFG_RESET;
         t_q.phase      <= SINGLE_PHASE;
         t_q.rdata      <= 8'h00;
         t_q.guard      <= 1'b0;
      end else begin
         t_q <= t_d;
      end
   end

   assign regs_if.gate_drive = t_q.gate_drive;
   assign regs_if.phase_cfg  = t_q.phase_cfg;

   // ==========================================================
   // Outputs
   assign reg_rdata_out                 = t_q.rdata;
   assign high_side_drive_strength_out  = t_q.gate_drive[HS_LSB +: 3];
   assign low_side_drive_strength_out   = t_q.gate_drive[LS_LSB +: 3];
   assign battery_overvoltage_guard_out = t_q.guard;
   assign dual_phase_out                = (t_q.phase == DUAL_PHASE);
endmodule : phase_gate_config

// [rtl/reg_access_if.sv]
// Interface: gate drive and phase register contents between top and phase controller
`timescale 1ns/100ps
interface reg_access_if;
   logic [7:0] gate_drive;
   logic [7:0] phase_cfg;
   modport regs (output gate_drive, output phase_cfg);
   modport ctrl (input gate_drive, input phase_cfg);
endinterface : reg_access_if

// [tb/phase_and_gate_drive_config_tb_top.sv]
// Testbench: register access, overvoltage guard and phase transitions
`timescale 1ns/100ps
module phase_and_gate_drive_config_tb_top;
   // ==========================================================
   // Stimulus, expectation queue and monitor
   logic       clk_in = 0, reset_n_in = 0, wr = 0, rrst = 0, quasi = 0, buck = 0;
   logic       en = 0, chg = 0, bsw = 0, rd = 0, rd_d = 0, guard, dual;
   logic [7:0] addr = 0, wdata = 0, rdata, d;
   logic [3:0] load = 0;
   logic [2:0] hs, ls;
   logic [7:0] exp_q[$];
   int         mismatches = 0, checks = 0, n;
   int         alim[4] = '{170, 550, 2000, 8600};
   int         dlim[4] = '{9300, 50, 60, 70};
   // Short drop limits keep the run brief
   phase_gate_config #(.DROP_T1_CYC(50), .DROP_T2_CYC(60), .DROP_T3_CYC(70)) dut (
      .clk_in, .reset_n_in, .reg_wr_in(wr), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .reg_reset_in(rrst), .quasi_dual_mode_in(quasi),
      .buck_mode_in(buck), .load_current_a_in(load), .overvoltage_guard_enable_in(en),
      .charge_enable_in(chg), .battery_switch_in(bsw), .high_side_drive_strength_out(hs),
      .low_side_drive_strength_out(ls), .battery_overvoltage_guard_out(guard),
      .dual_phase_out(dual));
   task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic test_done();
      if (mismatches == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done
   task automatic write(logic [7:0] a, logic [7:0] v);
      @(posedge clk_in);
      addr <= a; wdata <= v; wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask : write
   task automatic read(logic [7:0] a, logic [7:0] e);
      @(posedge clk_in);
      addr <= a; rd <= 1'b1; exp_q.push_back(e);
      @(posedge clk_in);
      rd <= 1'b0;
   endtask : read
   task automatic wait_dual(logic v, int lo, int hi);
      n = 0;
      while (dual !== v && n < 10000) begin
         @(negedge clk_in);
         n++;
      end
      check("dual_time", 8'(n >= lo && n <= hi), 8'h01);
      @(posedge clk_in);
   endtask : wait_dual
   always @(posedge clk_in) rd_d <= rd;
   always @(negedge clk_in) if (rd_d) check("rdata", rdata, exp_q.pop_front());
   initial forever #5 clk_in = ~clk_in;
   initial begin
      #600000 mismatches++;
      test_done();
   end
   initial begin
      void'($urandom(7549));
      repeat (12) @(posedge clk_in);
      reset_n_in <= 1'b1;
      read(8'h13, 8'h6c);
      read(8'h14, 8'h85);
      check("hs", 8'(hs), 8'h03);
      check("ls", 8'(ls), 8'h03);
      for (int i = 0; i < 8; i++) begin
         d = {i[2:0], 3'(7 - i), 2'($urandom)};
         write(8'h13, d);
         @(negedge clk_in);
         check("hs", 8'(hs), 8'(i[2:0]));
         check("ls", 8'(ls), 8'(7 - i));
         read(8'h13, d & 8'hfd);
      end
      write(8'h15, 8'hff);
      read(8'h15, 8'h00);
      for (int i = 0; i < 16; i++) begin
         write(8'h13, {7'h36, i[3]});
         {en, chg, bsw} <= i[2:0];
         @(posedge clk_in);
         @(negedge clk_in);
         check("guard", 8'(guard), 8'(en & (i[3] | (chg & bsw))));
      end
      @(posedge clk_in);
      quasi <= 1'b1;
      buck <= 1'b1;
      for (int c = 1; c < 8; c++) begin
         write(8'h14, {c[2:0], 1'b0, c[1:0], c[1:0]});
         load <= 4'(c + 3);
         wait_dual(1'b1, alim[c % 4], alim[c % 4] + 10);
         load <= 4'(c + 2);
         repeat (80) @(posedge clk_in);
         check("dual_hold", 8'(dual), 8'h01);
         load <= 4'(c + 1);
         wait_dual(1'b0, dlim[c % 4], dlim[c % 4] + 10);
      end
      write(8'h14, 8'h21);
      load <= 4'h4;
      repeat (100) @(posedge clk_in);
      load <= 4'h0;
      repeat (3) @(posedge clk_in);
      load <= 4'h4;
      wait_dual(1'b1, 170, 180);
      write(8'h14, 8'h31);
      wait_dual(1'b0, 1, 6);
      write(8'h14, 8'h05);
      wait_dual(1'b1, 1, 6);
      buck <= 1'b0;
      wait_dual(1'b0, 1, 6);
      buck <= 1'b1;
      wait_dual(1'b1, 1, 6);
      quasi <= 1'b0;
      wait_dual(1'b0, 1, 6);
      rrst <= 1'b1;
      @(posedge clk_in);
      rrst <= 1'b0;
      read(8'h14, 8'h85);
      read(8'h13, 8'h6c);
      @(posedge clk_in);
      test_done();
   end
endmodule : phase_and_gate_drive_config_tb_top

// [tb/phase_gate_config_sva.sv]
// Checker: port assertions for the phase and gate drive configuration block
`timescale 1ns/100ps
module phase_gate_config_sva (
   input wire logic       clk_in,
   input wire logic       reset_n_in,
   input wire logic       reg_wr_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic       reg_reset_in,
   input wire logic       quasi_dual_mode_in,
   input wire logic       overvoltage_guard_enable_in,
   input wire logic       charge_enable_in,
   input wire logic       battery_switch_in,
   input wire logic [2:0] high_side_drive_strength_out,
   input wire logic [2:0] low_side_drive_strength_out,
   input wire logic       battery_overvoltage_guard_out,
   input wire logic       dual_phase_out
);
   // ==========================================================
   // Shadow of the extend bit and the last write data
   logic       ovx_q;
   logic [7:0] wd_q;
   wire        wr13 = reg_wr_in && !reg_reset_in && reg_addr_in == 8'h13;
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ovx_q <= 1'b0;
         wd_q  <= 8'h00;
      end else begin
         wd_q  <= reg_wdata_in;
         ovx_q <= reg_reset_in ? 1'b0 : (wr13 ? reg_wdata_in[0] : ovx_q);
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   a_hs_write_load: assert property (
      wr13 |=> high_side_drive_strength_out == wd_q[7:5])
      else $error("high-side strength not loaded");
   a_ls_write_load: assert property (
      wr13 |=> low_side_drive_strength_out == wd_q[4:2])
      else $error("low-side strength not loaded");
   a_reset_cmd_defaults: assert property (
      reg_reset_in |=>
      high_side_drive_strength_out == 3'h3 && low_side_drive_strength_out == 3'h3)
      else $error("register reset did not restore strengths");
   a_reserved_bit_zero: assert property (
      reg_addr_in == 8'h13 |=> !reg_rdata_out[1])
      else $error("reserved bit reads one");
   a_unmapped_read_zero: assert property (
      !(reg_addr_in inside {8'h13, 8'h14}) |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   a_guard_charging_on: assert property (
      overvoltage_guard_enable_in && charge_enable_in && battery_switch_in
      |=> battery_overvoltage_guard_out)
      else $error("guard off while charging");
   a_guard_extend_on: assert property (
      overvoltage_guard_enable_in && ovx_q && !reg_wr_in && !reg_reset_in
      |=> battery_overvoltage_guard_out)
      else $error("extended guard off");
   a_guard_normal_off: assert property (
      !ovx_q && !(charge_enable_in && battery_switch_in) && !reg_wr_in
      |=> !battery_overvoltage_guard_out)
      else $error("guard on without charging");
   a_quasi_off_single: assert property (
      !quasi_dual_mode_in [*4] |=> !dual_phase_out)
      else $error("dual phase outside quasi mode");
endmodule : phase_gate_config_sva
bind phase_gate_config phase_gate_config_sva chk (.clk_in, .reset_n_in, .reg_wr_in,
   .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_reset_in, .quasi_dual_mode_in,
   .overvoltage_guard_enable_in, .charge_enable_in, .battery_switch_in,
   .high_side_drive_strength_out, .low_side_drive_strength_out,
   .battery_overvoltage_guard_out, .dual_phase_out);
